// *** dcrb_map.vh ***
// register offsets, bit positions and codes for the drive command register bank
// assumes a 16-bit register-number port from the serial protocol decoder
`ifndef DCRB_MAP_VH
`define DCRB_MAP_VH
`define DCRB_REG_RESERVED   16'h0000
`define DCRB_REG_RUN_CMD    16'h0001
`define DCRB_RUN_CMD_RST    16'h0000
`define DCRB_BIT_RUN0       0
`define DCRB_BIT_RUN1       1
`define DCRB_BIT_EXT_FAULT  2
`define DCRB_BIT_FAULT_RST  3
`define DCRB_MFI_LSB        4
`define DCRB_MFI_MSB        10
`define DCRB_USED_MASK      16'h07ff
`define DCRB_FN_FREQ_REF    8'h28
`define DCRB_FN_RUN_SRC     8'h29
`define DCRB_FN_COMM_TEST   8'h43
`define DCRB_TEST_PATTERN   8'ha5
`define DCRB_TEST_BYTES     4'h8
`endif

// *** dcrb_lpbk.v ***
// loopback self-test engine for the serial link
// assumes tx and rx are bit-serial on clk; rx already synchronised by caller
`timescale 1ns/1ns
`include "dcrb_map.vh"
module dcrb_lpbk (
  input  wire       clk,      // system clock
  input  wire       rst,      // async reset, active high
  input  wire       start,    // one-cycle start pulse
  input  wire       rx_bit,   // looped receive bit
  output reg        tx_bit,   // transmit bit
  output reg        done,     // test finished, level
  output reg        pass      // result, valid with done
);
  localparam ST_IDLE = 2'd0;
  localparam ST_SEND = 2'd1;
  localparam ST_END  = 2'd2;
  reg [1:0] state_ff;
  reg [2:0] bit_ff;
  reg [3:0] byte_ff;
  reg       ok_ff;
  // loop latency is four cycles: tx_bit flop, tx pin flop plus two rx sync flops
  reg [3:0] chk_ff;
  reg [3:0] exp_ff;
  wire [7:0] pat = `DCRB_TEST_PATTERN ^ {4'h0, byte_ff};
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      bit_ff   <= 3'h0;
      byte_ff  <= 4'h0;
      ok_ff    <= 1'b1;
      chk_ff   <= 4'h0;
      exp_ff   <= 4'h0;
      tx_bit   <= 1'b1;
      done     <= 1'b0;
      pass     <= 1'b0;
    end else begin
      // compare the bit sent four cycles earlier with what came back
      if (chk_ff[3] && (rx_bit != exp_ff[3]))
        ok_ff <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          chk_ff <= 4'h0;
          if (start) begin
            state_ff <= ST_SEND;
            ok_ff    <= 1'b1;
            bit_ff   <= 3'h0;
            byte_ff  <= 4'h0;
          end
        end
        ST_SEND: begin
          tx_bit <= pat[bit_ff];
          exp_ff <= {exp_ff[2:0], pat[bit_ff]};
          chk_ff <= {chk_ff[2:0], 1'b1};
          bit_ff <= bit_ff + 3'h1;
          if (bit_ff == 3'h7) begin
            byte_ff <= byte_ff + 4'h1;
            if (byte_ff == `DCRB_TEST_BYTES - 4'h1)
              state_ff <= ST_END;
          end
        end
        ST_END: begin
          // drain the pipe so the last bits are checked
          chk_ff <= {chk_ff[2:0], 1'b0};
          exp_ff <= {exp_ff[2:0], 1'b0};
          tx_bit <= 1'b1;
          if (chk_ff == 4'h0) begin
            done <= 1'b1;
            pass <= ok_ff;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end
endmodule // dcrb_lpbk

// *** dcrb_top.v ***
// drive command register bank with serial loopback self-test
// assumes a protocol decoder giving register writes/reads as one-cycle strobes on clk
`timescale 1ns/1ns
`include "dcrb_map.vh"
module dcrb_top (
  input  wire        clk,                        // 50 MHz clock
  input  wire        rst,                        // async reset = power-up, active high
  input  wire        wr_stb,                     // register write strobe
  input  wire        rd_stb,                     // register read strobe
  input  wire [15:0] reg_addr,                   // register number
  input  wire [15:0] wr_data,                    // write data
  input  wire        run_command_method_select,  // run command method
  input  wire [7:0]  input1_function_select,     // input 1 function code
  input  wire [7:0]  input2_function_select,     // input 2 function code
  input  wire [7:0]  input6_function_select,     // input 6 function code
  input  wire        option_card_fitted,         // comm option card present (pin)
  input  wire        input_terminal_six,         // jumper to common present (pin)
  input  wire        rx_pin,                     // serial receive pin
  input  wire        tx_user,                    // normal transmit data
  output reg  [15:0] rd_data_ff,                 // read data
  output reg         rd_valid_ff,                // read data valid pulse
  output reg         rd_error_ff,                // read of unmapped register
  output reg         fwd_run_ff,                 // forward run command
  output reg         rev_run_ff,                 // reverse run command
  output reg         option_external_fault_ff,   // external fault raised
  output reg         fault_reset_ff,             // fault reset request pulse
  output reg  [6:0]  mfi_ff,                     // multi-function inputs 1..7
  output reg         serial_freq_ref_ff,         // freq reference from serial link
  output reg         serial_run_src_ff,          // run source from serial link
  output reg         tx_pin_ff,                  // serial transmit pin
  output reg         rx_user_ff,                 // received data to normal path
  output reg         test_mode_ff,               // self-test active
  output reg         selftest_ok_indication_ff,  // self-test pass display
  output reg         link_error_indication_ff    // self-test fail display
);
  reg  [15:0] run_cmd_ff;
  reg         opt_s1_ff, opt_s2_ff;
  reg         jmp_s1_ff, jmp_s2_ff;
  reg         rx_s1_ff, rx_s2_ff;
  reg  [1:0]  arm_ff;
  reg         armed_ff;
  reg         started_ff;
  wire        lb_tx;
  wire        lb_done;
  wire        lb_pass;
  wire        wr_run = wr_stb && (reg_addr == `DCRB_REG_RUN_CMD);
  wire        start  = armed_ff && !started_ff;

  // pins cross into clk domain
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      opt_s1_ff <= 1'b0;
      opt_s2_ff <= 1'b0;
      jmp_s1_ff <= 1'b0;
      jmp_s2_ff <= 1'b0;
      rx_s1_ff  <= 1'b1;
      rx_s2_ff  <= 1'b1;
    end else begin
      opt_s1_ff <= option_card_fitted;
      opt_s2_ff <= opt_s1_ff;
      jmp_s1_ff <= input_terminal_six;
      jmp_s2_ff <= jmp_s1_ff;
      rx_s1_ff  <= rx_pin;
      rx_s2_ff  <= rx_s1_ff;
    end
  end

  // command word storage and readback
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      run_cmd_ff  <= `DCRB_RUN_CMD_RST;
      rd_data_ff  <= 16'h0000;
      rd_valid_ff <= 1'b0;
      rd_error_ff <= 1'b0;
    end else begin
      // reserved bits kept zero in case master slips
      if (wr_run)
        run_cmd_ff <= wr_data & `DCRB_USED_MASK;
      rd_valid_ff <= rd_stb;
      // reserved register reads zero, writes ignored
      rd_error_ff <= rd_stb && (reg_addr != `DCRB_REG_RUN_CMD) && (reg_addr != `DCRB_REG_RESERVED);
      if (rd_stb)
        rd_data_ff <= (reg_addr == `DCRB_REG_RUN_CMD) ? run_cmd_ff : 16'h0000;
    end
  end

  // decoded drive commands; forced off during self-test
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      fwd_run_ff               <= 1'b0;
      rev_run_ff               <= 1'b0;
      option_external_fault_ff <= 1'b0;
      fault_reset_ff           <= 1'b0;
      mfi_ff                   <= 7'h00;
      serial_freq_ref_ff       <= 1'b0;
      serial_run_src_ff        <= 1'b0;
    end else if (test_mode_ff) begin
      fwd_run_ff               <= 1'b0;
      rev_run_ff               <= 1'b0;
      option_external_fault_ff <= 1'b0;
      fault_reset_ff           <= 1'b0;
      mfi_ff                   <= 7'h00;
      serial_freq_ref_ff       <= 1'b0;
      serial_run_src_ff        <= 1'b0;
    end else begin
      if (run_command_method_select) begin
        fwd_run_ff <= run_cmd_ff[`DCRB_BIT_RUN0] && !run_cmd_ff[`DCRB_BIT_RUN1];
        rev_run_ff <= run_cmd_ff[`DCRB_BIT_RUN0] && run_cmd_ff[`DCRB_BIT_RUN1];
      end else begin
        // separate fwd/rev, both set means stop
        fwd_run_ff <= run_cmd_ff[`DCRB_BIT_RUN0] && !run_cmd_ff[`DCRB_BIT_RUN1];
        rev_run_ff <= run_cmd_ff[`DCRB_BIT_RUN1] && !run_cmd_ff[`DCRB_BIT_RUN0];
      end
      option_external_fault_ff <= run_cmd_ff[`DCRB_BIT_EXT_FAULT];
      // reset request on each write with bit set
      fault_reset_ff <= wr_run && wr_data[`DCRB_BIT_FAULT_RST];
      mfi_ff <= run_cmd_ff[`DCRB_MFI_MSB:`DCRB_MFI_LSB];
      serial_freq_ref_ff <= (input1_function_select == `DCRB_FN_FREQ_REF) &&
                            run_cmd_ff[`DCRB_MFI_LSB] && !opt_s2_ff;
      serial_run_src_ff <= (input2_function_select == `DCRB_FN_RUN_SRC) &&
                           run_cmd_ff[`DCRB_MFI_LSB + 1];
    end
  end

  // test mode latched once after power-up; setting needs jumper too
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      arm_ff       <= 2'h3;
      armed_ff     <= 1'b0;
      started_ff   <= 1'b0;
      test_mode_ff <= 1'b0;
    end else begin
      // synced jumper is only valid two edges after release
      if (arm_ff != 2'h0)
        arm_ff <= arm_ff - 2'h1;
      // sampled only at power-up with jumper fitted
      if (arm_ff == 2'h1)
        armed_ff <= (input6_function_select == `DCRB_FN_COMM_TEST) && jmp_s2_ff;
      if (start)
        started_ff <= 1'b1;
      // stays in test until power removed
      test_mode_ff <= armed_ff;
    end
  end

  dcrb_lpbk u_lpbk (
    .clk    (clk),
    .rst    (rst),
    .start  (start),
    .rx_bit (rx_s2_ff),
    .tx_bit (lb_tx),
    .done   (lb_done),
    .pass   (lb_pass)
  );

  // link muxing and result display
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_pin_ff                 <= 1'b1;
      rx_user_ff                <= 1'b1;
      selftest_ok_indication_ff <= 1'b0;
      link_error_indication_ff  <= 1'b0;
    end else begin
      // transmit own data in test mode
      tx_pin_ff  <= test_mode_ff ? lb_tx : tx_user;
      rx_user_ff <= test_mode_ff ? 1'b1 : rx_s2_ff;
      selftest_ok_indication_ff <= test_mode_ff && lb_done && lb_pass;
      link_error_indication_ff  <= test_mode_ff && lb_done && !lb_pass;
    end
  end
endmodule // dcrb_top

// *** dcrb_chk_asserts.sv ***
// checker for the command word decode, read answers and self-test result
// assumes it is bound to dcrb_top and sees only its ports
`timescale 1ns/1ns
module dcrb_chk (
  input wire        clk,                        // clock
  input wire        rst,                        // reset
  input wire        wr_stb,                     // write strobe
  input wire        rd_stb,                     // read strobe
  input wire [15:0] reg_addr,                   // register number
  input wire [15:0] wr_data,                    // write data
  input wire        run_command_method_select,  // method
  input wire [7:0]  input1_function_select,     // input 1 code
  input wire [7:0]  input2_function_select,     // input 2 code
  input wire        option_card_fitted,         // option card pin
  input wire        rd_valid_ff,                // read valid
  input wire        rd_error_ff,                // read error
  input wire        fwd_run_ff,                 // forward run
  input wire        rev_run_ff,                 // reverse run
  input wire        option_external_fault_ff,   // external fault
  input wire        fault_reset_ff,             // fault reset
  input wire [6:0]  mfi_ff,                     // inputs 1..7
  input wire        serial_freq_ref_ff,         // serial freq ref
  input wire        serial_run_src_ff,          // serial run source
  input wire        test_mode_ff,               // test mode
  input wire        selftest_ok_indication_ff,  // pass display
  input wire        link_error_indication_ff    // fail display
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // stored word and its delayed copy: decoded outputs lag the store by one
  reg [15:0] word_ff, q_ff;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      word_ff <= 16'h0000;
      q_ff <= 16'h0000;
    end else begin
      if (wr_stb && reg_addr == 16'h0001)
        word_ff <= wr_data & 16'h07ff;
      q_ff <= word_ff;
    end
  end
  sequence cmd_wr;
    wr_stb && reg_addr == 16'h0001 && !test_mode_ff;
  endsequence
  rd_answer_a:
    assert property (rd_stb |=> rd_valid_ff) else $error("read not answered");
  bad_addr_a:
    assert property (rd_stb && reg_addr > 16'h0001 |=> rd_error_ff) else $error("no read error");
  rst_pulse_a:
    assert property (cmd_wr ##0 wr_data[3] |=> fault_reset_ff) else $error("no fault reset");
  ext_fault_a:
    assert property (!test_mode_ff |-> option_external_fault_ff == q_ff[2]) else $error("ext fault");
  fwd_run_a:
    assert property (!test_mode_ff |-> fwd_run_ff == (q_ff[0] && !q_ff[1])) else $error("fwd run");
  rev_run_a:
    assert property (!test_mode_ff |-> rev_run_ff == ($past(run_command_method_select) ?
      q_ff[0] && q_ff[1] : q_ff[1] && !q_ff[0])) else $error("rev run");
  mfi_map_a:
    assert property (!test_mode_ff |-> mfi_ff == q_ff[10:4]) else $error("mfi map");
  freq_src_a:
    assert property (!test_mode_ff |-> serial_freq_ref_ff == (q_ff[4] &&
      $past(input1_function_select) == 8'h28 && !$past(option_card_fitted, 3))) else $error("freq src");
  run_src_a:
    assert property (!test_mode_ff |-> serial_run_src_ff == (q_ff[5] &&
      $past(input2_function_select) == 8'h29)) else $error("run src");
  test_quiet_a:
    assert property (test_mode_ff |-> !fwd_run_ff && !rev_run_ff) else $error("run in test");
  result_hold_a:
    assert property (link_error_indication_ff |=> link_error_indication_ff) else $error("result lost");
  ok_hold_a:
    assert property (selftest_ok_indication_ff |=> selftest_ok_indication_ff) else $error("pass lost");
  result_mode_a:
    assert property (selftest_ok_indication_ff || link_error_indication_ff |-> test_mode_ff)
      else $error("result outside test");
endmodule // dcrb_chk
bind dcrb_top dcrb_chk u_chk (.*);

// *** dcrb_master.sv ***
// serial-link master model: one-cycle write and read strobes
// assumes the bank samples on rising clk and answers reads one cycle later
`timescale 1ns/1ns
module dcrb_master (
  input  wire        clk,          // clock
  input  wire [15:0] rd_data_ff,   // read data
  input  wire        rd_valid_ff,  // read valid
  input  wire        rd_error_ff,  // read error
  output reg         wr_stb,       // write strobe
  output reg         rd_stb,       // read strobe
  output reg  [15:0] reg_addr,     // register number
  output reg  [15:0] wr_data       // write data
);
  initial begin
    wr_stb = 1'h0;
    rd_stb = 1'h0;
    reg_addr = 16'hffff;
    wr_data = 16'h0000;
  end
  // only the command word, spare bits zero
  task wr(input [15:0] d);
    begin
      @(negedge clk);
      wr_stb = 1'h1;
      reg_addr = 16'h0001;
      wr_data = d & 16'h07ff;
      @(negedge clk);
      wr_stb = 1'h0;
      reg_addr = 16'hfffe;
      wr_data = ~wr_data;
    end
  endtask
  task rd(input [15:0] a, output [15:0] d, output e, output v);
    begin
      @(negedge clk);
      rd_stb = 1'h1;
      reg_addr = a;
      @(negedge clk);
      d = rd_data_ff;
      e = rd_error_ff;
      v = rd_valid_ff;
      rd_stb = 1'h0;
      reg_addr = ~a;
    end
  endtask
endmodule // dcrb_master

// *** test_drive_command_register_bank.sv ***
// testbench for the drive command register bank
// assumes dcrb_top, dcrb_master and the bound checker are compiled first
`timescale 1ns/1ns
module test_drive_command_register_bank;
  reg clk = 1'h0, rst = 1'h1, run_command_method_select = 1'h0, option_card_fitted = 1'h0;
  reg input_terminal_six = 1'h0, loop_on = 1'h0, tx_user = 1'h1;
  reg [7:0] input1_function_select = 8'h00, input2_function_select = 8'h00, input6_function_select = 8'h00;
  wire wr_stb, rd_stb, rd_valid_ff, rd_error_ff, fwd_run_ff, rev_run_ff, option_external_fault_ff;
  wire fault_reset_ff, serial_freq_ref_ff, serial_run_src_ff, tx_pin_ff, rx_user_ff, test_mode_ff;
  wire selftest_ok_indication_ff, link_error_indication_ff;
  wire [15:0] reg_addr, wr_data, rd_data_ff;
  wire [6:0] mfi_ff;
  // jumper loop: transmit pin wired back to receive, else line idles high
  wire rx_pin = loop_on ? tx_pin_ff : 1'h1;
  reg [15:0] d;
  reg e, v;
  integer n_errors = 0, n_compared = 0, cyc = 0, i;
  dcrb_top u_dut (.*);
  dcrb_master u_mst (.*);
  always #10 clk = ~clk;
  task close_out;
    begin
      $display("compared %0d, mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  task chk(input string nm, input [15:0] seen, input [15:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task tick(input integer n);
    repeat (n) @(negedge clk);
  endtask
  // the whole run is well under a thousand cycles
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 4000) begin
      n_errors = n_errors + 1;
      close_out;
    end
  end
  initial begin
    tick(4);
    rst = 1'h0;
    u_mst.rd(16'h0001, d, e, v);
    chk("word", d, 16'h0000);
    chk("valid", 16'(v), 16'h0001);
    for (i = 0; i < 8; i = i + 1) begin
      run_command_method_select = i[2];
      u_mst.wr({14'h0000, i[1:0]});
      tick(2);
      chk("fwd", 16'(fwd_run_ff), 16'(i[0] & ~i[1]));
      chk("rev", 16'(rev_run_ff), 16'(i[2] ? i[0] & i[1] : i[1] & ~i[0]));
    end
    u_mst.wr(16'h000c);
    chk("frst", 16'(fault_reset_ff), 16'h0001);
    tick(1);
    chk("efault", 16'(option_external_fault_ff), 16'h0001);
    chk("frst", 16'(fault_reset_ff), 16'h0000);
    input1_function_select = 8'h28;
    input2_function_select = 8'h29;
    u_mst.wr(16'h07f0);
    tick(2);
    chk("mfi", 16'(mfi_ff), 16'h007f);
    chk("fref", 16'(serial_freq_ref_ff), 16'h0001);
    chk("rsrc", 16'(serial_run_src_ff), 16'h0001);
    option_card_fitted = 1'h1;
    tick(5);
    chk("fref", 16'(serial_freq_ref_ff), 16'h0000);
    chk("rsrc", 16'(serial_run_src_ff), 16'h0001);
    option_card_fitted = 1'h0;
    input1_function_select = 8'h00;
    tick(5);
    chk("fref", 16'(serial_freq_ref_ff), 16'h0000);
    u_mst.rd(16'h0001, d, e, v);
    chk("word", d, 16'h07f0);
    u_mst.rd(16'h0000, d, e, v);
    chk("rsvd", {d[14:0], e}, 16'h0000);
    u_mst.rd(16'h0005, d, e, v);
    chk("err", 16'(e), 16'h0001);
    // loop left open: receive line stuck high must fail the self-test
    input6_function_select = 8'h43;
    input_terminal_six = 1'h1;
    rst = 1'h1;
    tick(4);
    rst = 1'h0;
    for (i = 0; i < 400 && !(selftest_ok_indication_ff | link_error_indication_ff); i = i + 1)
      tick(1);
    chk("tmode", 16'(test_mode_ff), 16'h0001);
    chk("lerr", 16'(link_error_indication_ff), 16'h0001);
    chk("ok", 16'(selftest_ok_indication_ff), 16'h0000);
    u_mst.wr(16'h0001);
    tick(2);
    chk("fwd", 16'(fwd_run_ff), 16'h0000);
    tick(50);
    chk("lerr", 16'(link_error_indication_ff), 16'h0001);
    // loop closed: own data must come back intact
    loop_on = 1'h1;
    rst = 1'h1;
    tick(4);
    rst = 1'h0;
    for (i = 0; i < 400 && !(selftest_ok_indication_ff | link_error_indication_ff); i = i + 1)
      tick(1);
    chk("ok", 16'(selftest_ok_indication_ff), 16'h0001);
    chk("lerr", 16'(link_error_indication_ff), 16'h0000);
    chk("rxu", 16'(rx_user_ff), 16'h0001);
    tick(20);
    chk("ok", 16'(selftest_ok_indication_ff), 16'h0001);
    input6_function_select = 8'h00;
    input_terminal_six = 1'h0;
    rst = 1'h1;
    tick(4);
    rst = 1'h0;
    tick(3);
    chk("tmode", 16'(test_mode_ff), 16'h0000);
    chk("lerr", 16'(link_error_indication_ff), 16'h0000);
    chk("ok", 16'(selftest_ok_indication_ff), 16'h0000);
    tx_user = 1'h0;
    tick(6);
    chk("txp", 16'(tx_pin_ff), 16'h0000);
    chk("rxu", 16'(rx_user_ff), 16'h0000);
    tx_user = 1'h1;
    close_out;
  end
endmodule // test_drive_command_register_bank
